/* rtl/nmt_slave_pkg.sv */
// Purpose: Constants and types shared by the network-management slave block
// Assumes: 100 MHz clock, frames arrive already decoded by a CAN controller
// Notes:   Register offsets are the object indices
package nmt_slave_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [15:0] OFS_POLL_INTERVAL = 16'h100C;
   localparam logic [15:0] OFS_MISSED_LIMIT  = 16'h100D;
   localparam logic [15:0] OFS_NODE_STATUS   = 16'h1100;
   localparam logic [15:0] RST_POLL_INTERVAL = 16'h0000;
   localparam logic [7:0]  RST_MISSED_LIMIT  = 8'h00;

   // ----------------------------------------------------------------
   // Frame identifiers and command codes
   // ----------------------------------------------------------------
   localparam logic [10:0] ID_NODE_CONTROL = 11'h000;
   localparam logic [10:0] ID_ERROR_CTRL   = 11'h700;
   localparam logic [7:0]  CMD_START       = 8'h01;
   localparam logic [7:0]  CMD_STOP        = 8'h02;
   localparam logic [7:0]  CMD_PREOP       = 8'h80;
   localparam logic [7:0]  CMD_RESET_NODE  = 8'h81;
   localparam logic [7:0]  CMD_RESET_COMM  = 8'h82;
   localparam logic [7:0]  DEST_ALL        = 8'h00;
   localparam logic [6:0]  MAX_NODE_ID     = 7'h7F;
   localparam logic [7:0]  BOOTUP_BYTE     = 8'h00;

   // ----------------------------------------------------------------
   // Reported state codes
   // ----------------------------------------------------------------
   localparam logic [6:0] CODE_STOPPED = 7'h04;
   localparam logic [6:0] CODE_OPER    = 7'h05;
   localparam logic [6:0] CODE_PREOP   = 7'h7F;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ      = 100;
   localparam int TICK_US      = 1000;
   localparam int TICK_CYCLES  = CLK_MHZ * TICK_US;
   localparam int INIT_CYCLES  = 4;

   // Node communication state, Gray along init-preop-oper-stop
   typedef enum logic [1:0] {
      ST_INIT    = 2'b00,
      ST_PREOP   = 2'b01,
      ST_OPER    = 2'b11,
      ST_STOPPED = 2'b10
   } node_state_type;

endpackage

/* rtl/ms_tick.sv */
// Purpose: Millisecond tick generator
// Assumes: Single clock, synchronous active-low reset
// Notes:   Restarts its count whenever clear is high
`timescale 1ns/1ps
module ms_tick #(
   parameter int CYCLES = 100000            // Cycles per tick
) (
   input  wire logic clk,                   // System clock
   input  wire logic rst_n,                 // Sync reset, active low
   input  wire logic clear,                 // Restart the count
   output logic      tick                   // One-cycle pulse per period
);
   logic [31:0] countReg;
   logic        tickReg;
   logic        atEnd;

   // Terminal count decode
   assign atEnd = (countReg == 32'(CYCLES - 1));
   assign tick  = tickReg;

   // Free-running divider
   always_ff @(posedge clk) begin
      if (!rst_n || clear) begin
         countReg <= 32'h0000_0000;
         tickReg  <= 1'b0;
      end else begin
         countReg <= atEnd ? 32'h0000_0000 : countReg + 32'h0000_0001;
         tickReg  <= atEnd;
      end
   end
endmodule // ms_tick

/* rtl/guard_timer.sv */
// Purpose: Slave-side poll supervision timer
// Assumes: Tick is a one-cycle pulse per millisecond
// Notes:   Counts elapsed milliseconds against interval times limit
`timescale 1ns/1ps
module guard_timer (
   input  wire logic        clk,            // System clock
   input  wire logic        rst_n,          // Sync reset, active low
   input  wire logic        restart,        // Supervision reset (comm reset)
   input  wire logic        poll,           // Poll received pulse
   input  wire logic        tick,           // Millisecond tick
   input  wire logic [15:0] interval,       // Poll interval in ms
   input  wire logic [7:0]  limit,          // Missed-poll limit
   output logic             armed,          // Timing is running
   output logic             timeout         // One-cycle timeout pulse
);
   logic [23:0] elapsedReg;
   logic        armedReg;
   logic        timeoutReg;
   logic        enabled;
   logic [23:0] total;
   logic        expired;

   assign total   = interval * limit;
   assign enabled = (interval != 16'h0000) && (limit != 8'h00);
   assign expired = armedReg && enabled && tick && (elapsedReg + 24'h000001 >= total);
   assign armed   = armedReg;
   assign timeout = timeoutReg;

   always_ff @(posedge clk) begin
      if (!rst_n || restart) begin
         armedReg   <= 1'b0;
         elapsedReg <= 24'h000000;
         timeoutReg <= 1'b0;
      end else begin
         timeoutReg <= expired;
         if (poll) begin
            armedReg   <= 1'b1;
            elapsedReg <= 24'h000000;
         end else if (expired) begin
            armedReg   <= 1'b0;
            elapsedReg <= 24'h000000;
         end else if (armedReg && enabled && tick) begin
            elapsedReg <= elapsedReg + 24'h000001;
         end
      end
   end

   chk_disabled_quiet: assert property (@(posedge clk) disable iff (!rst_n)
      !enabled |=> !timeoutReg) else $error("timeout while disabled");
   chk_idle_unarmed: assert property (@(posedge clk) disable iff (!rst_n)
      (!armedReg && !poll) |=> !timeoutReg) else $error("timeout while unarmed");
endmodule // guard_timer

/* rtl/canopen_nmt_slave_guarding.sv */
// Purpose: Network-management slave with node state machine and poll supervision
// Assumes: A CAN controller hands over received frames and takes frames to send
// Notes:
// Notes on behaviour
// - Power-on enters initialization, then moves to preoperational by itself.
// - During initialization no bus traffic is accepted or answered.
// - Leaving initialization sends one boot-up frame, id 700h plus address, byte zero.
// - Preoperational enables service data, SYNC, emergency, NMT; process data off.
// - Operational enables every communication object.
// - Stopped suppresses everything except network-management frames.
// - Node-control frame: id 00h, byte one command, byte two destination.
// - Node-control commands are never acknowledged.
// - Code 1 enters operational, code 2 enters stopped.
// - Code 128 enters preoperational from operational or stopped.
// - Code 129 makes a full device reset through initialization.
// - Code 130 resets communication only, then re-enters initialization.
// - Commands for address 0 or own address are executed, others ignored.
// - Poll interval, 16 bits in ms, at poll_interval_ms, reset zero.
// - Missed-poll limit, 8 bits at missed_poll_limit; timeout at interval times limit.
// - Zero interval or zero limit disables supervision.
// - Supervision starts only at the first poll.
// - Each poll that arrives while no frame is waiting to be sent is answered with one byte holding the state code.
// - Bit 7 of the reply toggles on every reply.
// - Supervision timeout returns to preoperational and sets guardFault; the lamp shows only the node state.
// - Master expects replies; missing polls let the slave detect a fault.
`timescale 1ns/1ps
module canopen_nmt_slave_guarding #(
   parameter int TICK_CYC = nmt_slave_pkg::TICK_CYCLES  // Cycles per millisecond
) (
   input  wire logic        clk,            // System clock
   input  wire logic        rst_n,          // Sync reset, active low
   input  wire logic [6:0]  nodeAddr,       // Node address strap, 1..127
   input  wire logic        rxValid,        // Received frame strobe
   input  wire logic [10:0] rxId,           // Received identifier
   input  wire logic        rxRemote,       // Received frame is remote
   input  wire logic [3:0]  rxLen,          // Received data length
   input  wire logic [7:0]  rxByte0,        // Received byte 1
   input  wire logic [7:0]  rxByte1,        // Received byte 2
   output logic             txValid,        // Frame to send is waiting
   input  wire logic        txReady,        // Controller takes the frame
   output logic [10:0]      txId,           // Identifier to send
   output logic [3:0]       txLen,          // Length to send
   output logic [7:0]       txByte0,        // Data byte to send
   input  wire logic [15:0] regAddr,        // Register address
   input  wire logic [15:0] regWdata,       // Register write data
   input  wire logic        regWr,          // Write strobe
   input  wire logic        regRd,          // Read strobe
   output logic [15:0]      regRdata,       // Read data, one cycle later
   output logic             pdoEnable,      // Process data allowed
   output logic             sdoEnable,      // Service data allowed
   output logic             syncEnable,     // SYNC allowed
   output logic             emcyEnable,     // Emergency allowed
   output logic             nmtEnable,      // Network management allowed
   output logic             deviceReset,    // Full device reset pulse
   output logic             commReset,      // Communication reset pulse
   output logic [1:0]       busStatusLamp,  // Lamp shows node state
   output logic             guardFault      // Supervision error seen, sticky
);
   import nmt_slave_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   node_state_type stateReg, stateNext;
   logic [6:0]  addrReg;
   logic [15:0] intervalReg;
   logic [7:0]  limitReg;
   logic [2:0]  initCntReg;
   logic        toggleReg;
   logic        faultReg;
   logic        txValidReg;
   logic [10:0] txIdReg;
   logic [3:0]  txLenReg;
   logic [7:0]  txByteReg;
   logic [15:0] rdataReg;
   logic        devRstReg;
   logic        comRstReg;
   logic        initDone;
   logic        ctrlFrame;
   logic        forMe;
   logic        pollFrame;
   logic        doStart;
   logic        doStop;
   logic        doPreop;
   logic        doResetNode;
   logic        doResetComm;
   logic        anyReset;
   logic        tick;
   logic        armed;
   logic        timeout;
   logic        txTaken;
   logic [7:0]  replyByte;

   // Map state to its reported code
   function automatic logic [6:0] state_code(input node_state_type s);
      unique case (s)
         ST_STOPPED: state_code = CODE_STOPPED;
         ST_OPER:    state_code = CODE_OPER;
         ST_PREOP:   state_code = CODE_PREOP;
         ST_INIT:    state_code = 7'h00;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Frame decode
   // ----------------------------------------------------------------
   // node-control frame layout
   assign ctrlFrame = rxValid && !rxRemote && (rxId == ID_NODE_CONTROL) && (rxLen == 4'h2)
                      && (stateReg != ST_INIT);
   assign forMe = (rxByte1 == DEST_ALL) || (rxByte1 == {1'b0, addrReg});
   assign doStart     = ctrlFrame && forMe && (rxByte0 == CMD_START);
   assign doStop      = ctrlFrame && forMe && (rxByte0 == CMD_STOP);
   assign doPreop     = ctrlFrame && forMe && (rxByte0 == CMD_PREOP);
   assign doResetNode = ctrlFrame && forMe && (rxByte0 == CMD_RESET_NODE);
   assign doResetComm = ctrlFrame && forMe && (rxByte0 == CMD_RESET_COMM);
   assign anyReset    = doResetNode || doResetComm;
   // poll is a remote frame on 700h plus address
   assign pollFrame = rxValid && rxRemote && (rxId == (ID_ERROR_CTRL | {4'h0, addrReg}))
                      && (stateReg != ST_INIT);
   assign initDone  = (stateReg == ST_INIT) && (initCntReg == 3'(INIT_CYCLES - 1));
   assign txTaken   = txValidReg && txReady;
   // state code, toggle in bit 7
   assign replyByte = {toggleReg, state_code(stateReg)};

   // ----------------------------------------------------------------
   // Node state machine
   // ----------------------------------------------------------------
   // Next state selection, commands win over timeout
   always_comb begin
      stateNext = stateReg;
      unique case (stateReg)
         ST_INIT: begin
            if (initDone) begin
               stateNext = ST_PREOP;
            end
         end
         default: begin
            if (anyReset) begin
               stateNext = ST_INIT;
            end else if (doStart) begin
               stateNext = ST_OPER;
            end else if (doStop) begin
               stateNext = ST_STOPPED;
            end else if (doPreop) begin
               stateNext = ST_PREOP;
            end else if (timeout) begin
               stateNext = ST_PREOP;
            end
         end
      endcase
   end

   // State register and init counter
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stateReg   <= ST_INIT;
         initCntReg <= 3'h0;
      end else begin
         stateReg   <= stateNext;
         initCntReg <= (stateReg == ST_INIT && !initDone) ? initCntReg + 3'h1 : 3'h0;
      end
   end

   // Address follows nodeAddr while initializing, held in all other states
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         addrReg <= 7'h00;
      end else if (stateReg == ST_INIT) begin
         addrReg <= nodeAddr;
      end
   end

   // ----------------------------------------------------------------
   // Object enables per state
   // ----------------------------------------------------------------
   // access per state
   assign pdoEnable  = (stateReg == ST_OPER);
   assign sdoEnable  = (stateReg == ST_OPER) || (stateReg == ST_PREOP);
   assign syncEnable = sdoEnable;
   assign emcyEnable = sdoEnable;
   assign nmtEnable  = (stateReg != ST_INIT);
   assign busStatusLamp = stateReg;

   // ----------------------------------------------------------------
   // Transmit path
   // ----------------------------------------------------------------
   // boot-up then poll replies; commands send nothing
   always_ff @(posedge clk) begin
      if (!rst_n || anyReset) begin
         txValidReg <= 1'b0;
         txIdReg    <= 11'h000;
         txLenReg   <= 4'h0;
         txByteReg  <= 8'h00;
      end else if (initDone) begin
         txValidReg <= 1'b1;
         txIdReg    <= ID_ERROR_CTRL | {4'h0, addrReg};
         txLenReg   <= 4'h1;
         txByteReg  <= BOOTUP_BYTE;
      end else if (pollFrame && (!txValidReg || txTaken)) begin
         txValidReg <= 1'b1;
         txIdReg    <= ID_ERROR_CTRL | {4'h0, addrReg};
         txLenReg   <= 4'h1;
         txByteReg  <= replyByte;
      end else if (txTaken) begin
         txValidReg <= 1'b0;
      end
   end
   assign txValid = txValidReg;
   assign txId    = txIdReg;
   assign txLen   = txLenReg;
   assign txByte0 = txByteReg;

   // toggle per reply, cleared in initialization
   always_ff @(posedge clk) begin
      if (!rst_n || stateReg == ST_INIT) begin
         toggleReg <= 1'b0;
      end else if (pollFrame && (!txValidReg || txTaken)) begin
         toggleReg <= ~toggleReg;
      end
   end

   // ----------------------------------------------------------------
   // Reset pulses
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         devRstReg <= 1'b0;
         comRstReg <= 1'b0;
      end else begin
         devRstReg <= doResetNode;
         comRstReg <= doResetComm;
      end
   end
   assign deviceReset = devRstReg;
   assign commReset   = comRstReg;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // settings; cleared by either reset
   always_ff @(posedge clk) begin
      if (!rst_n || anyReset) begin
         intervalReg <= RST_POLL_INTERVAL;
         limitReg    <= RST_MISSED_LIMIT;
      end else if (regWr && regAddr == OFS_POLL_INTERVAL) begin
         intervalReg <= regWdata;
      end else if (regWr && regAddr == OFS_MISSED_LIMIT) begin
         limitReg <= regWdata[7:0];
      end
   end

   // Sticky fault, set wins over clear by write of bit 0
   always_ff @(posedge clk) begin
      if (!rst_n || anyReset) begin
         faultReg <= 1'b0;
      end else if (timeout) begin
         faultReg <= 1'b1;
      end else if (regWr && regAddr == OFS_NODE_STATUS && regWdata[0]) begin
         faultReg <= 1'b0;
      end
   end
   assign guardFault = faultReg;

   // Read data one cycle after strobe
   always_ff @(posedge clk) begin
      if (!rst_n || !regRd) begin
         rdataReg <= 16'h0000;
      end else if (regAddr == OFS_POLL_INTERVAL) begin
         rdataReg <= intervalReg;
      end else if (regAddr == OFS_MISSED_LIMIT) begin
         rdataReg <= {8'h00, limitReg};
      end else if (regAddr == OFS_NODE_STATUS) begin
         rdataReg <= {3'h0, armed, toggleReg, stateReg, 1'b0, state_code(stateReg), faultReg};
      end else begin
         rdataReg <= 16'h0000;
      end
   end
   assign regRdata = rdataReg;

   // ----------------------------------------------------------------
   // Supervision
   // ----------------------------------------------------------------
   ms_tick #(.CYCLES(TICK_CYC)) u_tick (
      .clk   (clk),
      .rst_n (rst_n),
      .clear (1'b0),
      .tick  (tick)
   );

   guard_timer u_guard (
      .clk      (clk),
      .rst_n    (rst_n),
      .restart  (anyReset || stateReg == ST_INIT),
      .poll     (pollFrame),
      .tick     (tick),
      .interval (intervalReg),
      .limit    (limitReg),
      .armed    (armed),
      .timeout  (timeout)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence initEnd;
      stateReg == ST_INIT && initDone;
   endsequence
   chk_init_to_preop: assert property (@(posedge clk) disable iff (!rst_n)
      initEnd |=> stateReg == ST_PREOP) else $error("init did not reach preop");
   chk_bootup_frame: assert property (@(posedge clk) disable iff (!rst_n)
      initEnd |=> txValid && txLen == 4'h1 && txByte0 == 8'h00) else $error("bad boot-up");
   chk_init_silent: assert property (@(posedge clk) disable iff (!rst_n)
      stateReg == ST_INIT |-> !pollFrame && !ctrlFrame) else $error("traffic in init");
   chk_pdo_gating: assert property (@(posedge clk) disable iff (!rst_n)
      pdoEnable |-> stateReg == ST_OPER) else $error("pdo outside operational");
   chk_stop_only_nmt: assert property (@(posedge clk) disable iff (!rst_n)
      stateReg == ST_STOPPED |-> !sdoEnable && !pdoEnable && nmtEnable) else $error("stopped leak");
   chk_start_cmd: assert property (@(posedge clk) disable iff (!rst_n)
      doStart && !anyReset |=> stateReg == ST_OPER) else $error("start ignored");
   chk_preop_cmd: assert property (@(posedge clk) disable iff (!rst_n)
      doPreop |=> stateReg == ST_PREOP) else $error("preop ignored");
   chk_reset_cmd: assert property (@(posedge clk) disable iff (!rst_n)
      anyReset |=> stateReg == ST_INIT) else $error("reset ignored");
   chk_timeout_preop: assert property (@(posedge clk) disable iff (!rst_n)
      timeout && !ctrlFrame |=> stateReg == ST_PREOP && guardFault) else $error("timeout no fallback");
   chk_reply_toggle: assert property (@(posedge clk) disable iff (!rst_n)
      pollFrame && (!txValidReg || txTaken) && !initDone && !anyReset
      |=> txByte0[7] == $past(toggleReg) && toggleReg != $past(toggleReg)) else $error("toggle wrong");
endmodule // canopen_nmt_slave_guarding

/* dv/can_master_model.sv */
// Purpose: Network master and CAN controller model
// Assumes: Frames pass already decoded
// Notes:   stall delays txReady by that many cycles
`timescale 1ns/1ps
module can_master_model (
   input  wire logic        clk,      // Clock
   output logic             rxValid,  // Frame strobe
   output logic [10:0]      rxId,     // Identifier
   output logic             rxRemote, // Remote flag
   output logic [3:0]       rxLen,    // Length
   output logic [7:0]       rxByte0,  // Byte 1
   output logic [7:0]       rxByte1,  // Byte 2
   input  wire logic        txValid,  // Frame waiting
   output logic             txReady,  // Frame taken
   input  wire logic [10:0] txId,     // Identifier
   input  wire logic [3:0]  txLen,    // Length
   input  wire logic [7:0]  txByte0   // Data byte
);
   int          stall = 0;
   int          waitCnt = 0;
   logic [22:0] txSeen[$];
   // Idle lines
   initial begin
      {rxValid, rxId, rxRemote, rxLen, rxByte0, rxByte1} = '0;
   end
   task automatic send(input logic [10:0] id, input logic rem, input logic [3:0] len,
                       input logic [7:0] b0, input logic [7:0] b1);
      @(posedge clk);
      {rxValid, rxId, rxRemote, rxLen, rxByte0, rxByte1} <= {1'b1, id, rem, len, b0, b1};
      @(posedge clk);
      {rxValid, rxId, rxRemote, rxLen, rxByte0, rxByte1} <= {1'b0, ~{id, rem, len, b0, b1}};
   endtask
   assign txReady = txValid && (waitCnt >= stall);
   always @(posedge clk) begin
      waitCnt <= (txValid && !txReady) ? waitCnt + 1 : 0;
      if (txValid && txReady) txSeen.push_back({txId, txLen, txByte0});
   end
endmodule // can_master_model

/* dv/tb_canopen_nmt_slave_guarding.sv */
// Purpose: Self-checking bench for the NMT slave
// Assumes: Tick shortened to 10 cycles
// Notes:   Node address 5
`timescale 1ns/1ps
module tb_canopen_nmt_slave_guarding;
   import nmt_slave_pkg::*;
   localparam logic [6:0]  ADDR = 7'h05;
   localparam logic [10:0] GID  = ID_ERROR_CTRL | {4'h0, ADDR};
   logic        clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
   logic [15:0] regAddr = 16'h0000, regWdata = 16'h0000, regRdata;
   logic        rxValid, rxRemote, txValid, txReady, deviceReset, commReset, guardFault;
   logic [10:0] rxId, txId;
   logic [3:0]  rxLen, txLen;
   logic [7:0]  rxByte0, rxByte1, txByte0;
   logic [4:0]  en;
   logic [1:0]  lamp;
   logic        tog = 1'b0;
   int          failures = 0, n_compared = 0, nDev = 0, nComm = 0;
   logic [7:0]  tc[8] = '{CMD_START, CMD_STOP, CMD_START, CMD_PREOP, CMD_START, CMD_PREOP, CMD_STOP, CMD_PREOP};
   logic [7:0]  td[8] = '{8'h05, 8'h00, 8'h06, 8'h05, 8'h00, 8'h00, 8'h05, 8'h05};
   logic [1:0]  ts[8] = '{ST_OPER, ST_STOPPED, ST_STOPPED, ST_PREOP, ST_OPER, ST_PREOP, ST_STOPPED, ST_PREOP};
   canopen_nmt_slave_guarding #(.TICK_CYC(10)) i_dut (.clk(clk), .rst_n(rst_n), .nodeAddr(ADDR),
      .rxValid(rxValid), .rxId(rxId), .rxRemote(rxRemote), .rxLen(rxLen), .rxByte0(rxByte0),
      .rxByte1(rxByte1), .txValid(txValid), .txReady(txReady), .txId(txId), .txLen(txLen),
      .txByte0(txByte0), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .pdoEnable(en[4]), .sdoEnable(en[3]), .syncEnable(en[2]),
      .emcyEnable(en[1]), .nmtEnable(en[0]), .deviceReset(deviceReset), .commReset(commReset),
      .busStatusLamp(lamp), .guardFault(guardFault));
   can_master_model m (.clk(clk), .rxValid(rxValid), .rxId(rxId), .rxRemote(rxRemote),
      .rxLen(rxLen), .rxByte0(rxByte0), .rxByte1(rxByte1), .txValid(txValid), .txReady(txReady),
      .txId(txId), .txLen(txLen), .txByte0(txByte0));
   // Clock and reset pulse counters
   always #5 clk = ~clk;
   always @(posedge clk) begin
      nDev <= nDev + deviceReset;
      nComm <= nComm + commReset;
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_frame(input logic [7:0] b);
      logic [22:0] f;
      f = 'x;
      repeat (100) if (m.txSeen.size() == 0) @(posedge clk);
      if (m.txSeen.size() != 0) f = m.txSeen.pop_front();
      chk(f, {GID, 4'h1, b});
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      {regWr, regAddr, regWdata} <= {1'b1, a, d};
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      @(posedge clk);
      {regRd, regAddr} <= {1'b1, a};
      @(posedge clk);
      regRd <= 1'b0;
      #1 chk(regRdata, exp);
   endtask
   task automatic poll();
      m.send(GID, 1'b1, 4'h0, 8'h00, 8'h00);
   endtask
   task automatic cmd(input logic [7:0] c, input logic [7:0] d);
      m.send(ID_NODE_CONTROL, 1'b0, 4'h2, c, d);
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic pollchk(input logic [6:0] code);
      poll();
      chk_frame({tog, code});
      tog = ~tog;
   endtask
   task automatic end_of_test();
      $display("compared=%0d failures=%0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Watchdog
   initial begin
      #100us;
      failures++;
      end_of_test();
   end
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      poll();
      #1 chk(lamp, ST_INIT);
      chk_frame(BOOTUP_BYTE);
      repeat (6) @(posedge clk);
      chk(m.txSeen.size(), 0);
      chk({lamp, en}, {ST_PREOP, 5'b01111});
      rd(OFS_POLL_INTERVAL, RST_POLL_INTERVAL);
      rd(OFS_MISSED_LIMIT, {8'h00, RST_MISSED_LIMIT});
      wr(OFS_POLL_INTERVAL, 16'hA5C3);
      rd(OFS_POLL_INTERVAL, 16'hA5C3);
      rd(16'h2000, 16'h0000);
      pollchk(CODE_PREOP);
      m.stall = 3;
      pollchk(CODE_PREOP);
      m.stall = 0;
      for (int i = 0; i < 8; i++) begin
         cmd(tc[i], td[i]);
         chk(m.txSeen.size(), 0);
         chk(lamp, ts[i]);
         chk(en, ts[i] == ST_OPER ? 5'b11111 : ts[i] == ST_PREOP ? 5'b01111 : 5'b00001);
         pollchk(ts[i] == ST_OPER ? CODE_OPER : ts[i] == ST_PREOP ? CODE_PREOP : CODE_STOPPED);
      end
      cmd(CMD_RESET_COMM, {1'b0, ADDR});
      chk_frame(BOOTUP_BYTE);
      tog = 1'b0;
      cmd(CMD_START, {1'b0, ADDR});
      wr(OFS_POLL_INTERVAL, 16'h0002);
      wr(OFS_MISSED_LIMIT, 16'h0003);
      repeat (150) @(posedge clk);
      chk(guardFault, 1'b0);
      pollchk(CODE_OPER);
      repeat (40) @(posedge clk);
      chk(guardFault, 1'b0);
      repeat (30) @(posedge clk);
      chk({guardFault, lamp}, {1'b1, ST_PREOP});
      rd(OFS_NODE_STATUS, {3'h0, 1'b0, tog, ST_PREOP, 1'b0, CODE_PREOP, 1'b1});
      wr(OFS_NODE_STATUS, 16'h0001);
      wr(OFS_MISSED_LIMIT, 16'h0000);
      pollchk(CODE_PREOP);
      repeat (150) @(posedge clk);
      chk(guardFault, 1'b0);
      for (int k = 0; k < 2; k++) begin
         wr(OFS_POLL_INTERVAL, 16'h0007);
         cmd(k == 0 ? CMD_RESET_NODE : CMD_RESET_COMM, DEST_ALL);
         chk_frame(BOOTUP_BYTE);
         rd(OFS_POLL_INTERVAL, 16'h0000);
         tog = 1'b0;
         pollchk(CODE_PREOP);
      end
      chk({nDev, nComm}, {32'd1, 32'd2});
      end_of_test();
   end
endmodule // tb_canopen_nmt_slave_guarding
